// file: common/mhif_pkg.sv
// Shared constants and types for the motion hold input flag block.
package mhif_pkg;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int NUM_INPUTS = 6;
  localparam int SEL_W      = 3;
  localparam int MODE_W     = 2;
  localparam int DIST_W     = 32;
  localparam int EV_W       = 4;

  localparam logic [ADDR_W-1:0] OFF_CFG     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_REMAIN  = 8'h18;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_HSEL_LSB = 4;
  localparam int CFG_HPOL_BIT = 7;
  localparam int CFG_ASEL_LSB = 8;
  localparam int CFG_APOL_BIT = 11;

  localparam int CMD_RESUME_BIT  = 0;
  localparam int CMD_ABANDON_BIT = 1;

  localparam int ST_HOLD_BIT  = 0;
  localparam int ST_ABN_BIT   = 1;
  localparam int ST_HELD_BIT  = 2;
  localparam int ST_DECEL_BIT = 3;

  localparam int EV_HOLD_IN = 0;
  localparam int EV_HELD    = 1;
  localparam int EV_DISCARD = 2;
  localparam int EV_RESUME  = 3;

  localparam logic [MODE_W-1:0] MODE_ZERO = 2'h0;
  localparam logic [SEL_W-1:0]  SEL_NONE  = 3'h0;
  localparam logic              POL_RST   = 1'b1;
  localparam logic [EV_W-1:0]   EV_RST    = 4'h0;
  localparam logic [DIST_W-1:0] DIST_RST  = 32'h0;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_DECEL = 2'b01,
    S_HELD  = 2'b11
  } mhif_state_type;
endpackage

// file: rtl/mhif_pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module mhif_pin_sync #(
  parameter int W = 6
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         srst,
  // Raw and filtered levels.
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);
  wire  [W-1:0] q_next = (s2_reg & agree) | (q & ~agree);

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= q_next;
    end
  end
endmodule
`default_nettype wire

// file: rtl/mhif_route.sv
// Routes one of the system inputs to a function flag with selectable level.
`timescale 1ns/1ps
`default_nettype none
module mhif_route #(
  parameter int N = 6
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       srst,
  // Synchronised inputs and routing setup.
  input  wire logic [N-1:0] pins,
  input  wire logic [2:0] sel,
  input  wire logic       pol,
  input  wire logic       mode_zero,
  // Function flag.
  output logic            flag
);
  wire [2:0] idx    = sel - 3'h1;
  wire       routed = (sel != 3'h0) && (32'(sel) <= N);
  wire       flag_next = mode_zero && routed && (pins[idx] == pol); // [RL2] [RL3] [RL12] [RL13]

  always_ff @(posedge clk) begin
    if (srst) begin
      flag <= 1'b0;
    end else begin
      flag <= flag_next;
    end
  end
endmodule
`default_nettype wire

// file: rtl/mhif_top.sv
// Motion hold and hold-abandon flags, hold sequencing and register file.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RL1] A read-only flag mirrors the logical state of the hold input.
// [RL2] Hold flag is 1 only when routed and the routed input is asserted.
// [RL3] An unrouted hold function forces the hold flag to zero.
// [RL4] Hold input asserted during a move requests a decelerated stop.
// [RL5] A held move resumes on command, or on start while a sequence runs.
// [RL6] Abandon input or abandon command discards the rest of a held move.
// [RL7] In mode 0 the hold function routes to any of six inputs.
// [RL8] In modes 1 to 3 the hold function is unavailable.
// [RL9] A polarity setting picks the asserted level of the hold input.
// [RL10] The abandon flag is read-only and starts at zero.
// [RL11] A flag mirrors the logical state of the abandon input.
// [RL12] Abandon flag is 1 only when routed and the routed input is asserted.
// [RL13] An unrouted abandon function forces the abandon flag to zero.
// [RL14] In mode 0 the abandon function routes to any of six inputs.
// [RL15] In modes 1 to 3 the abandon function is unavailable.
// [RL16] A separate polarity setting picks the asserted abandon level.
// [RL17] Hold flag reads 0 inactive, 1 asserted, and starts at zero.
// [RL18] Remaining distance is kept while held, then resumed or discarded.
module mhif_top #(
  parameter int NUM_IN = mhif_pkg::NUM_INPUTS
) (
  // Clock and reset.
  input  wire logic                        CLK,
  input  wire logic                        SRST,
  // Register port.
  input  wire logic [mhif_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [mhif_pkg::DATA_W-1:0] WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [mhif_pkg::DATA_W-1:0] RDATA,
  // System input pins.
  input  wire logic [NUM_IN-1:0]           IN_PINS,
  // Motion engine and sequencer.
  input  wire logic                        MOVE_BUSY,
  input  wire logic                        MOTOR_STOPPED,
  input  wire logic                        SEQ_RUNNING,
  input  wire logic                        START_IN,
  input  wire logic [mhif_pkg::DIST_W-1:0] REMAIN_IN,
  output logic                             DECEL_REQ,
  output logic                             RESUME_PULSE,
  output logic                             DISCARD_PULSE,
  output logic      [mhif_pkg::DIST_W-1:0] REMAIN_OUT,
  // Flags and interrupt.
  output logic                             HOLD_FLAG,
  output logic                             ABANDON_FLAG,
  output logic                             IRQ
);
  import mhif_pkg::*;

  logic [MODE_W-1:0] mode_reg;
  logic [SEL_W-1:0]  hsel_reg;
  logic              hpol_reg;
  logic [SEL_W-1:0]  asel_reg;
  logic              apol_reg;
  logic [EV_W-1:0]   ist_reg;
  logic [EV_W-1:0]   ien_reg;
  logic              hold_d_reg;
  logic [NUM_IN-1:0] pins_s;
  logic              hold_flag;
  logic              ab_flag;
  mhif_state_type    state_reg;
  mhif_state_type    state_next;

  // Register decode.
  wire wr_cfg  = WR && (ADDR == OFF_CFG);
  wire wr_cmd  = WR && (ADDR == OFF_CMD);
  wire wr_clr  = WR && (ADDR == OFF_IRQ_CLR);
  wire wr_ien  = WR && (ADDR == OFF_IRQ_EN);
  wire resume_cmd  = wr_cmd && WDATA[CMD_RESUME_BIT];
  wire abandon_cmd = wr_cmd && WDATA[CMD_ABANDON_BIT];
  wire mode_zero   = (mode_reg == MODE_ZERO);

  // Input conditioning and routing.
  mhif_pin_sync #(
    .W (NUM_IN)
  ) u_sync (
    .clk     (CLK),
    .srst    (SRST),
    .d_async (IN_PINS),
    .q       (pins_s)
  );

  // Both functions exist only in mode 0. [RL7] [RL8] [RL9]
  mhif_route #(
    .N (NUM_IN)
  ) u_hold (
    .clk       (CLK),
    .srst      (SRST),
    .pins      (pins_s),
    .sel       (hsel_reg),
    .pol       (hpol_reg),
    .mode_zero (mode_zero),
    .flag      (hold_flag)
  );

  // Abandon routing has its own selector and level. [RL14] [RL15] [RL16]
  mhif_route #(
    .N (NUM_IN)
  ) u_abandon (
    .clk       (CLK),
    .srst      (SRST),
    .pins      (pins_s),
    .sel       (asel_reg),
    .pol       (apol_reg),
    .mode_zero (mode_zero),
    .flag      (ab_flag)
  );

  assign HOLD_FLAG    = hold_flag; // [RL1]
  assign ABANDON_FLAG = ab_flag; // [RL11]

  // Hold sequencing.
  wire start_resume = SEQ_RUNNING && START_IN;
  wire go_discard   = (state_reg == S_HELD) && (ab_flag || abandon_cmd);
  wire go_resume    = (state_reg == S_HELD) && !go_discard && !hold_flag
                      && (resume_cmd || start_resume);
  wire go_held      = (state_reg == S_DECEL) && MOTOR_STOPPED;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (hold_flag && MOVE_BUSY) begin
          state_next = S_DECEL; // [RL4]
        end
      end
      S_DECEL: begin
        if (MOTOR_STOPPED) begin
          state_next = S_HELD;
        end
      end
      S_HELD: begin
        if (go_discard || go_resume) begin
          state_next = S_IDLE; // [RL5] [RL6]
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Motion outputs; the remaining distance survives resume and is cleared only by reset or discard or reloaded by the next hold.
  wire [DIST_W-1:0] remain_next = go_held ? REMAIN_IN :
                                  go_discard ? DIST_RST : REMAIN_OUT; // [RL18]

  always_ff @(posedge CLK) begin
    if (SRST) begin
      DECEL_REQ     <= 1'b0;
      RESUME_PULSE  <= 1'b0;
      DISCARD_PULSE <= 1'b0;
      REMAIN_OUT    <= DIST_RST;
    end else begin
      DECEL_REQ     <= (state_next == S_DECEL); // [RL4]
      RESUME_PULSE  <= go_resume; // [RL5]
      DISCARD_PULSE <= go_discard; // [RL6]
      REMAIN_OUT    <= remain_next;
    end
  end

  // Configuration register.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_reg <= MODE_ZERO;
      hsel_reg <= SEL_NONE;
      hpol_reg <= POL_RST;
      asel_reg <= SEL_NONE;
      apol_reg <= POL_RST;
    end else if (wr_cfg) begin
      mode_reg <= WDATA[CFG_MODE_LSB +: MODE_W];
      hsel_reg <= WDATA[CFG_HSEL_LSB +: SEL_W];
      hpol_reg <= WDATA[CFG_HPOL_BIT];
      asel_reg <= WDATA[CFG_ASEL_LSB +: SEL_W];
      apol_reg <= WDATA[CFG_APOL_BIT];
    end
  end

  // Interrupts: a new event wins over a clear in the same cycle.
  wire [EV_W-1:0] events = {go_resume, go_discard, go_held,
                            hold_flag && !hold_d_reg};
  wire [EV_W-1:0] clr_mask = wr_clr ? WDATA[EV_W-1:0] : EV_RST;
  wire [EV_W-1:0] ist_next = (ist_reg & ~clr_mask) | events;
  wire [EV_W-1:0] ien_next = wr_ien ? WDATA[EV_W-1:0] : ien_reg;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ist_reg    <= EV_RST;
      ien_reg    <= EV_RST;
      hold_d_reg <= 1'b0;
      IRQ        <= 1'b0;
    end else begin
      ist_reg    <= ist_next;
      ien_reg    <= ien_next;
      hold_d_reg <= hold_flag;
      IRQ        <= |(ist_next & ien_next);
    end
  end

  // Read path; data stand only in the cycle after the strobe.
  wire [DATA_W-1:0] cfg_word =
    DATA_W'({apol_reg, asel_reg, hpol_reg, hsel_reg, 2'h0, mode_reg});
  wire [DATA_W-1:0] st_word =
    DATA_W'({state_reg == S_DECEL, state_reg == S_HELD, ab_flag, hold_flag});
  wire [DATA_W-1:0] rd_mux =
    (ADDR == OFF_CFG)    ? cfg_word :
    (ADDR == OFF_STATUS) ? st_word : // [RL10] [RL17]
    (ADDR == OFF_IRQ_ST) ? DATA_W'(ist_reg) :
    (ADDR == OFF_IRQ_EN) ? DATA_W'(ien_reg) :
    (ADDR == OFF_REMAIN) ? DATA_W'(REMAIN_OUT) : '0;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? rd_mux : '0;
    end
  end

  // Checks.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence held_resume_s;
    state_reg == S_HELD && resume_cmd && !abandon_cmd && !ab_flag && !hold_flag;
  endsequence

  sequence resume_pulse_s;
    RESUME_PULSE && state_reg == S_IDLE ##1 !RESUME_PULSE;
  endsequence

  sequence held_abandon_s;
    state_reg == S_HELD && (ab_flag || abandon_cmd);
  endsequence

  a_hold_flag_zero: assert property ( // [RL3]
    (hsel_reg == SEL_NONE || !mode_zero) |=> !hold_flag)
    else $error("hold flag set while hold function unrouted");

  a_abandon_flag_zero: assert property ( // [RL13]
    (asel_reg == SEL_NONE || !mode_zero) |=> !ab_flag)
    else $error("abandon flag set while abandon function unrouted");

  a_hold_flag_pin: assert property ( // [RL2]
    (mode_zero && hsel_reg == 3'h1) |=> (hold_flag == ($past(pins_s[0]) == $past(hpol_reg))))
    else $error("hold flag does not follow routed input level");

  a_abandon_flag_pin: assert property ( // [RL12]
    (mode_zero && asel_reg == 3'h2) |=> (ab_flag == ($past(pins_s[1]) == $past(apol_reg))))
    else $error("abandon flag does not follow routed input level");

  a_flags_after_reset: assert property ( // [RL17]
    $past(SRST) |-> (!hold_flag && !ab_flag))
    else $error("flags not zero after reset");

  a_decel_on_hold: assert property ( // [RL4]
    (state_reg == S_IDLE && hold_flag && MOVE_BUSY) |=> DECEL_REQ
    ##0 (DECEL_REQ throughout (!MOTOR_STOPPED [*1])))
    else $error("hold during move did not request deceleration");

  a_remain_capture: assert property ( // [RL18]
    (state_reg == S_DECEL && MOTOR_STOPPED) |=>
    (state_reg == S_HELD && REMAIN_OUT == $past(REMAIN_IN) && !DECEL_REQ))
    else $error("remaining distance not kept at stop");

  a_resume_cmd: assert property ( // [RL5]
    held_resume_s |=> resume_pulse_s)
    else $error("resume command did not resume held move");

  a_abandon_held: assert property ( // [RL6]
    held_abandon_s |=> (DISCARD_PULSE && REMAIN_OUT == DIST_RST && !RESUME_PULSE))
    else $error("abandon did not discard held move");

  a_rdata_idle_zero: assert property ( // [RL10]
    !$past(RD) |-> (RDATA == '0))
    else $error("read data not zero outside the answer cycle");

  a_resume_refused: assert property ( // [RL5]
    (state_reg == S_HELD && hold_flag) |=> !RESUME_PULSE)
    else $error("held move resumed while hold input asserted");

  a_remain_kept: assert property ( // [RL18]
    (state_reg == S_HELD && !go_discard) |=> (REMAIN_OUT == $past(REMAIN_OUT)))
    else $error("remaining distance changed while held");
endmodule
`default_nettype wire

// file: bench/mhif_motion_model.sv
// Motion engine model that reports standstill some cycles after a deceleration request.
`timescale 1ns/1ps
`default_nettype none
module mhif_motion_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Bench control.
  input  wire logic        start_move,
  input  wire logic [3:0]  stop_dly,
  input  wire logic [31:0] remain_set,
  // Block side.
  input  wire logic        decel_req,
  input  wire logic        resume_pulse,
  output logic             move_busy,
  output logic             motor_stopped,
  output logic      [31:0] remain_in
);
  logic [3:0] cnt_reg;
  // The distance is only valid at standstill; while moving it shows a wrong value.
  assign remain_in = motor_stopped ? remain_set : ~remain_set;
  always_ff @(posedge clk) begin
    if (srst) begin
      move_busy     <= 1'b0;
      motor_stopped <= 1'b1;
      cnt_reg       <= 4'h0;
    end else if (start_move || resume_pulse) begin
      move_busy     <= 1'b1;
      motor_stopped <= 1'b0;
      cnt_reg       <= 4'h0;
    end else if (decel_req && move_busy) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg >= stop_dly) begin
        move_busy     <= 1'b0;
        motor_stopped <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the hold and hold-abandon flag block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("Error t=%0t value %h expected %h", $time, (a), (e)); end end
module testbench;
  import mhif_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] hs;
    logic       hp;
    logic [2:0] as;
    logic       ap;
    logic [5:0] pins;
    logic       eh;
    logic       ea;
  } mhif_row_type;
  logic              CLK = 1'b0;
  logic              SRST = 1'b1;
  logic [ADDR_W-1:0] ADDR = 8'h00;
  logic [DATA_W-1:0] WDATA = 32'h0;
  logic              WR = 1'b0;
  logic              RD = 1'b0;
  logic [5:0]        IN_PINS = 6'h00;
  logic              SEQ_RUNNING = 1'b0;
  logic              START_IN = 1'b0;
  logic              start_move = 1'b0;
  logic [3:0]        stop_dly = 4'h0;
  logic [31:0]       remain_set = 32'h0;
  logic [31:0]       rd_data;
  wire logic [31:0]  RDATA;
  wire logic [31:0]  REMAIN_IN;
  wire logic [31:0]  REMAIN_OUT;
  wire logic         MOVE_BUSY, MOTOR_STOPPED, DECEL_REQ, RESUME_PULSE, DISCARD_PULSE;
  wire logic         HOLD_FLAG, ABANDON_FLAG, IRQ;
  wire logic [3:0]   obs = {DISCARD_PULSE, RESUME_PULSE, DECEL_REQ, IRQ};
  int                n_fail = 0;
  int                tests_run = 0;
  mhif_row_type      rows [10];
  always #5 CLK = ~CLK;
  mhif_top i_dut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IN_PINS(IN_PINS), .MOVE_BUSY(MOVE_BUSY), .MOTOR_STOPPED(MOTOR_STOPPED),
    .SEQ_RUNNING(SEQ_RUNNING), .START_IN(START_IN), .REMAIN_IN(REMAIN_IN),
    .DECEL_REQ(DECEL_REQ), .RESUME_PULSE(RESUME_PULSE), .DISCARD_PULSE(DISCARD_PULSE),
    .REMAIN_OUT(REMAIN_OUT), .HOLD_FLAG(HOLD_FLAG), .ABANDON_FLAG(ABANDON_FLAG), .IRQ(IRQ));
  mhif_motion_model i_motion (.clk(CLK), .srst(SRST), .start_move(start_move),
    .stop_dly(stop_dly), .remain_set(remain_set), .decel_req(DECEL_REQ),
    .resume_pulse(RESUME_PULSE), .move_busy(MOVE_BUSY), .motor_stopped(MOTOR_STOPPED),
    .remain_in(REMAIN_IN));
  task automatic test_done();
    $display("Checks %0d, errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    rd_data = RDATA;
  endtask
  task automatic wait_obs(input int i, input logic v);
    int k;
    k = 0;
    while (obs[i] !== v && k < 60) begin
      @(posedge CLK);
      #1;
      k++;
    end
    if (obs[i] !== v) begin
      n_fail++;
      $display("Error t=%0t wait ran out", $time);
      test_done();
    end
  endtask
  // Starts a move, asserts the hold pin and waits until the move is held.
  task automatic hold_move(input logic [3:0] dly, input logic [31:0] rem);
    @(posedge CLK);
    stop_dly   <= dly;
    remain_set <= rem;
    start_move <= 1'b1;
    IN_PINS[0] <= 1'b1;
    @(posedge CLK);
    start_move <= 1'b0;
    #1;
    wait_obs(1, 1'b1);
    wait_obs(1, 1'b0);
    `CHK(MOTOR_STOPPED, 1'b1)
    `CHK(REMAIN_OUT, rem)
    rd(OFF_STATUS);
    `CHK(rd_data[ST_HELD_BIT], 1'b1)
    rd(OFF_REMAIN);
    `CHK(rd_data, rem)
  endtask
  initial begin
    rows[0] = '{2'h0, 3'h1, 1'h1, 3'h0, 1'h1, 6'h01, 1'h1, 1'h0};
    rows[1] = '{2'h0, 3'h6, 1'h1, 3'h0, 1'h1, 6'h20, 1'h1, 1'h0};
    rows[2] = '{2'h0, 3'h3, 1'h0, 3'h0, 1'h1, 6'h04, 1'h0, 1'h0};
    rows[3] = '{2'h0, 3'h3, 1'h0, 3'h0, 1'h1, 6'h3b, 1'h1, 1'h0};
    rows[4] = '{2'h0, 3'h0, 1'h1, 3'h0, 1'h1, 6'h3f, 1'h0, 1'h0};
    rows[5] = '{2'h0, 3'h7, 1'h1, 3'h7, 1'h1, 6'h3f, 1'h0, 1'h0};
    rows[6] = '{2'h0, 3'h0, 1'h1, 3'h2, 1'h1, 6'h02, 1'h0, 1'h1};
    rows[7] = '{2'h0, 3'h2, 1'h1, 3'h5, 1'h0, 6'h2d, 1'h0, 1'h1};
    rows[8] = '{2'h1, 3'h1, 1'h1, 3'h2, 1'h1, 6'h3f, 1'h0, 1'h0};
    rows[9] = '{2'h3, 3'h1, 1'h0, 3'h2, 1'h0, 6'h00, 1'h0, 1'h0};
    repeat (6) @(posedge CLK);
    SRST <= 1'b0;
    #1;
    `CHK({HOLD_FLAG, ABANDON_FLAG, IRQ}, 3'h0)
    rd(OFF_CFG);
    `CHK(rd_data, 32'h00000880)
    @(posedge CLK);
    #1;
    `CHK(RDATA, 32'h0)
    wr(OFF_STATUS, 32'hf);
    rd(OFF_STATUS);
    `CHK(rd_data, 32'h0)
    rd(8'h1c);
    `CHK(rd_data, 32'h0)
    foreach (rows[i]) begin
      wr(OFF_CFG, {20'h0, rows[i].ap, rows[i].as, rows[i].hp, rows[i].hs, 2'h0, rows[i].mode});
      IN_PINS <= rows[i].pins;
      repeat (8) @(posedge CLK);
      rd(OFF_STATUS);
      `CHK(rd_data[1:0], {rows[i].ea, rows[i].eh})
      `CHK({ABANDON_FLAG, HOLD_FLAG}, {rows[i].ea, rows[i].eh})
    end
    `CHK(IRQ, 1'b0)
    rd(OFF_IRQ_ST);
    `CHK(rd_data[EV_HOLD_IN], 1'b1)
    wr(OFF_CFG, 32'h00000a90);
    wr(OFF_IRQ_CLR, 32'hf);
    wr(OFF_IRQ_EN, 32'h1 << EV_HELD);
    IN_PINS <= 6'h00;
    repeat (8) @(posedge CLK);
    hold_move(4'h5, 32'h00001234);
    `CHK(IRQ, 1'b1)
    wr(OFF_CMD, 32'h1 << CMD_RESUME_BIT);
    IN_PINS <= 6'h00;
    #1;
    `CHK(RESUME_PULSE, 1'b0)
    repeat (8) @(posedge CLK);
    wr(OFF_CMD, 32'h1 << CMD_RESUME_BIT);
    #1;
    `CHK({RESUME_PULSE, REMAIN_OUT}, {1'b1, 32'h00001234})
    wr(OFF_IRQ_CLR, 32'hf);
    #1;
    `CHK(IRQ, 1'b0)
    hold_move(4'h0, 32'h00000abc);
    wr(OFF_CMD, 32'h1 << CMD_ABANDON_BIT);
    IN_PINS <= 6'h00;
    #1;
    `CHK({DISCARD_PULSE, REMAIN_OUT}, {1'b1, 32'h0})
    repeat (8) @(posedge CLK);
    wr(OFF_CMD, 32'h1 << CMD_RESUME_BIT);
    #1;
    `CHK(RESUME_PULSE, 1'b0)
    hold_move(4'h2, 32'h00000055);
    IN_PINS <= 6'h00;
    repeat (8) @(posedge CLK);
    SEQ_RUNNING <= 1'b1;
    START_IN    <= 1'b1;
    wait_obs(2, 1'b1);
    `CHK(REMAIN_OUT, 32'h00000055)
    SEQ_RUNNING <= 1'b0;
    START_IN    <= 1'b0;
    hold_move(4'h1, 32'h00000077);
    IN_PINS[1] <= 1'b1;
    wait_obs(3, 1'b1);
    `CHK(REMAIN_OUT, 32'h0)
    test_done();
  end
endmodule
`default_nettype wire
